// ===== bcm_pkg.sv
// Constants, types and state layout for the bit-clear / OR / move execute block
//----------------------------------------------------------------------
// Operation
// RQ1: Bit-clear zeroes chosen bit, no flags change
// RQ2: Literal-OR combines accumulator with low eight bits
// RQ3: Literal-OR writes accumulator, updates zero flag
// RQ4: Register-OR result goes by d, updates zero
// RQ5: Move-register copies f to accumulator or f
// RQ6: Move-register updates zero flag from moved value
// RQ7: Literal-OR takes accumulator, any literal 0..255
// RQ8: d zero selects accumulator, one selects file
// RQ9: One word, one cycle; zero means result zero
//----------------------------------------------------------------------
package bcm_pkg;

	// Instruction word layout
	localparam int INSTR_W = 12;
	localparam int DATA_W = 8;
	localparam int FADDR_W = 5;
	localparam int OPC4_MSB = 11;
	localparam int OPC4_LSB = 8;
	localparam int OPC6_LSB = 6;
	localparam int DEST_POS = 5;
	localparam int BITSEL_MSB = 7;
	localparam int BITSEL_LSB = 5;
	localparam int FADDR_MSB = 4;
	localparam int LIT_MSB = 7;
	localparam logic [3:0] OPC_BIT_CLEAR = 4'h4;
	localparam logic [3:0] OPC_OR_LIT = 4'hd;
	localparam logic [5:0] OPC_OR_FILE = 6'h04;
	localparam logic [5:0] OPC_MOVE_FILE = 6'h08;
	localparam logic DEST_ACCUM = 1'h0;

	// Register map, byte addresses
	localparam int REG_ADDR_W = 5;
	localparam logic [REG_ADDR_W-1:0] OFS_CTRL = 5'h00;
	localparam logic [REG_ADDR_W-1:0] OFS_ACCUM = 5'h04;
	localparam logic [REG_ADDR_W-1:0] OFS_STATUS = 5'h08;
	localparam logic [REG_ADDR_W-1:0] OFS_COUNT = 5'h0c;
	localparam int CTRL_EN_POS = 0;
	localparam int STAT_ZERO_POS = 0;
	localparam int STAT_UNSUP_POS = 1;
	localparam int STAT_DROP_POS = 2;
	localparam logic RST_EXEC_EN = 1'h1;
	localparam logic [DATA_W-1:0] RST_ACCUM = 8'h00;
	localparam int COUNT_W = 16;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum {OP_NONE, OP_BIT_CLEAR, OP_OR_LIT, OP_OR_FILE, OP_MOVE_FILE} bcm_op_type;

	typedef struct packed {
		logic valid;
		logic [INSTR_W-1:0] word;
	} bcm_instr_type;

	typedef struct packed {
		logic en;
		logic [FADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} bcm_file_wr_type;

	typedef struct packed {
		logic [DATA_W-1:0] accum;
		logic zero;
		bcm_file_wr_type file_wr;
		logic done;
		logic unsup;
		logic dropped;
		logic exec_en;
		logic [COUNT_W-1:0] count;
		logic aw_got;
		logic [REG_ADDR_W-1:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} bcm_state_type;

endpackage

// ===== bcm_execute.sv
// Execute stage for bit-clear, literal-OR, register-OR and move-register
`timescale 1ns/1ps
module bcm_execute
	import bcm_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Fetched instruction and addressed file register contents
	input bcm_instr_type instr,
	input wire logic [DATA_W-1:0] file_rd_data,
	// Results
	output bcm_file_wr_type file_wr,
	output logic [DATA_W-1:0] accum,
	output logic zero_flag,
	output logic exec_done,
	// AXI4-Lite slave
	input wire logic [REG_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [REG_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	bcm_state_type s_reg;
	bcm_state_type s_next;
	bcm_op_type op;
	logic [DATA_W-1:0] lit;
	logic [FADDR_W-1:0] faddr;
	logic [BITSEL_MSB-BITSEL_LSB:0] bitsel;
	logic dest_file;
	logic [DATA_W-1:0] result;
	logic [DATA_W-1:0] clear_mask;
	logic exec;

	//----------------------------------------------------------------------
	// Decode
	//----------------------------------------------------------------------
	always_comb
	begin
		op = OP_NONE;
		if (instr.word[OPC4_MSB:OPC4_LSB] == OPC_BIT_CLEAR)
			op = OP_BIT_CLEAR; // RQ1
		else if (instr.word[OPC4_MSB:OPC4_LSB] == OPC_OR_LIT)
			op = OP_OR_LIT; // RQ2
		else if (instr.word[OPC4_MSB:OPC6_LSB] == OPC_OR_FILE)
			op = OP_OR_FILE; // RQ4
		else if (instr.word[OPC4_MSB:OPC6_LSB] == OPC_MOVE_FILE)
			op = OP_MOVE_FILE; // RQ5
	end

	assign lit = instr.word[LIT_MSB:0];
	assign faddr = instr.word[FADDR_MSB:0];
	assign bitsel = instr.word[BITSEL_MSB:BITSEL_LSB];
	assign dest_file = instr.word[DEST_POS];
	// Only the chosen bit is forced low, the rest pass unchanged
	assign clear_mask = ~(DATA_W'(1) << bitsel); // RQ1
	assign exec = instr.valid && s_reg.exec_en;

	//----------------------------------------------------------------------
	// Result
	//----------------------------------------------------------------------
	always_comb
	begin
		result = file_rd_data;
		unique case (op)
			OP_BIT_CLEAR: result = file_rd_data & clear_mask; // RQ1
			OP_OR_LIT: result = s_reg.accum | lit; // RQ2 RQ7
			OP_OR_FILE: result = s_reg.accum | file_rd_data; // RQ4
			OP_MOVE_FILE: result = file_rd_data; // RQ5
			OP_NONE: result = file_rd_data;
		endcase
	end

	//----------------------------------------------------------------------
	// Read data mux
	//----------------------------------------------------------------------
	function automatic logic [33:0] read_reg(input logic [REG_ADDR_W-1:0] a, input bcm_state_type st);
		logic [31:0] d;
		logic [1:0] r;
		d = 32'h00000000;
		r = RESP_OKAY;
		unique case (a)
			OFS_CTRL: d[CTRL_EN_POS] = st.exec_en;
			OFS_ACCUM: d[DATA_W-1:0] = st.accum;
			OFS_STATUS:
			begin
				d[STAT_ZERO_POS] = st.zero;
				d[STAT_UNSUP_POS] = st.unsup;
				d[STAT_DROP_POS] = st.dropped;
			end
			OFS_COUNT: d[COUNT_W-1:0] = st.count;
			default: r = RESP_SLVERR;
		endcase
		return {r, d};
	endfunction

	//----------------------------------------------------------------------
	// Next state
	//----------------------------------------------------------------------
	always_comb
	begin
		s_next = s_reg;
		s_next.file_wr.en = 1'h0;
		s_next.done = 1'h0;

		// Write address and data may arrive in either order
		if (s_axi_awvalid && s_reg.awready)
		begin
			s_next.aw_got = 1'h1;
			s_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_reg.wready)
		begin
			s_next.w_got = 1'h1;
			s_next.w_data = s_axi_wdata;
			s_next.w_strb = s_axi_wstrb;
		end
		if (s_reg.bvalid && s_axi_bready)
			s_next.bvalid = 1'h0;

		// Software writes first so that an instruction in the same cycle wins
		if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid)
		begin
			s_next.aw_got = 1'h0;
			s_next.w_got = 1'h0;
			s_next.bvalid = 1'h1;
			s_next.bresp = RESP_OKAY;
			unique case (s_reg.aw_addr)
				OFS_CTRL:
					if (s_reg.w_strb[0])
						s_next.exec_en = s_reg.w_data[CTRL_EN_POS];
				OFS_ACCUM:
					if (s_reg.w_strb[0])
						s_next.accum = s_reg.w_data[DATA_W-1:0];
				OFS_STATUS:
					if (s_reg.w_strb[0])
					begin
						if (s_reg.w_data[STAT_UNSUP_POS])
							s_next.unsup = 1'h0;
						if (s_reg.w_data[STAT_DROP_POS])
							s_next.dropped = 1'h0;
					end
				OFS_COUNT: s_next.bresp = RESP_OKAY;
				default: s_next.bresp = RESP_SLVERR;
			endcase
		end
		s_next.awready = !s_next.aw_got && !s_next.bvalid;
		s_next.wready = !s_next.w_got && !s_next.bvalid;

		// Read channel, one outstanding read
		if (s_reg.rvalid && s_axi_rready)
			s_next.rvalid = 1'h0;
		if (s_axi_arvalid && s_reg.arready)
		begin
			s_next.rvalid = 1'h1;
			{s_next.rresp, s_next.rdata} = read_reg(s_axi_araddr, s_reg);
		end
		s_next.arready = !s_next.rvalid;

		// Instruction execution, one word completes per cycle
		if (instr.valid && !s_reg.exec_en)
			s_next.dropped = 1'h1;
		if (exec)
		begin
			s_next.done = 1'h1; // RQ9
			s_next.count = s_reg.count + COUNT_W'(1);
			unique case (op)
				OP_BIT_CLEAR:
				begin
					s_next.file_wr.en = 1'h1; // RQ1
					s_next.file_wr.addr = faddr;
					s_next.file_wr.data = result;
				end
				OP_OR_LIT:
				begin
					s_next.accum = result; // RQ3
					s_next.zero = (result == '0); // RQ3 RQ9
				end
				OP_OR_FILE, OP_MOVE_FILE:
				begin
					if (dest_file == DEST_ACCUM)
						s_next.accum = result; // RQ8 RQ4 RQ5
					else
					begin
						s_next.file_wr.en = 1'h1; // RQ8 RQ4 RQ5
						s_next.file_wr.addr = faddr;
						s_next.file_wr.data = result;
					end
					// A move back to itself doubles as a zero test
					s_next.zero = (result == '0); // RQ6 RQ4 RQ9
				end
				OP_NONE:
				begin
					s_next.done = 1'h0;
					s_next.count = s_reg.count;
					s_next.unsup = 1'h1;
				end
			endcase
		end
	end

	//----------------------------------------------------------------------
	// State register
	//----------------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			s_reg <= '0;
			s_reg.accum <= RST_ACCUM;
			s_reg.exec_en <= RST_EXEC_EN;
			s_reg.awready <= 1'h1;
			s_reg.wready <= 1'h1;
			s_reg.arready <= 1'h1;
		end
		else
			s_reg <= s_next;
	end

	//----------------------------------------------------------------------
	// Outputs
	//----------------------------------------------------------------------
	assign file_wr = s_reg.file_wr;
	assign accum = s_reg.accum;
	assign zero_flag = s_reg.zero;
	assign exec_done = s_reg.done;
	assign s_axi_awready = s_reg.awready;
	assign s_axi_wready = s_reg.wready;
	assign s_axi_bvalid = s_reg.bvalid;
	assign s_axi_bresp = s_reg.bresp;
	assign s_axi_arready = s_reg.arready;
	assign s_axi_rvalid = s_reg.rvalid;
	assign s_axi_rdata = s_reg.rdata;
	assign s_axi_rresp = s_reg.rresp;

endmodule // bcm_execute

// ===== bcm_checker.sv
// Concurrent checks on the instruction path of the execute block
`timescale 1ns/1ps
module bcm_checker
	import bcm_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Instruction side
	input bcm_instr_type instr,
	input wire logic [DATA_W-1:0] file_rd_data,
	// Results
	input bcm_file_wr_type file_wr,
	input wire logic [DATA_W-1:0] accum,
	input wire logic zero_flag,
	input wire logic exec_done
);
	logic [11:0] w;
	logic bc, ol, orf, mv, sup;
	assign w = instr.word;
	assign bc = instr.valid && w[11:8] == 4'h4;
	assign ol = instr.valid && w[11:8] == 4'hd;
	assign orf = instr.valid && w[11:6] == 6'h04;
	assign mv = instr.valid && w[11:6] == 6'h08;
	assign sup = bc || ol || orf || mv;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	AST_BCLR: assert property (bc |=> file_wr.en && file_wr.addr == $past(w[4:0])
		&& file_wr.data == ($past(file_rd_data) & ~(8'h01 << $past(w[7:5])))) else $error("bit clear data");
	AST_BCLR_FLAG: assert property (bc |=> $stable(zero_flag) && $stable(accum))
		else $error("bit clear side effect");
	AST_ORLIT: assert property (ol |=> accum == ($past(accum) | $past(w[7:0])))
		else $error("literal or value");
	AST_ORLIT_DEST: assert property (ol |=> !file_wr.en && zero_flag == (accum == 8'h00))
		else $error("literal or destination");
	AST_ORF_ACC: assert property (orf && !w[5] |=> !file_wr.en
		&& accum == ($past(accum) | $past(file_rd_data))) else $error("register or to accumulator");
	AST_ORF_FILE: assert property (orf && w[5] |=> file_wr.en && $stable(accum)
		&& file_wr.data == ($past(accum) | $past(file_rd_data)) && zero_flag == (file_wr.data == 8'h00))
		else $error("register or to file");
	AST_MOVE: assert property (mv |=> ($past(w[5]) ? file_wr.en && file_wr.data == $past(file_rd_data)
		: !file_wr.en && accum == $past(file_rd_data))) else $error("move destination");
	AST_MOVE_ZERO: assert property (mv |=> zero_flag == ($past(file_rd_data) == 8'h00))
		else $error("move zero flag");
	AST_DONE: assert property (sup |=> exec_done)
		else $error("done missing");
	AST_IDLE: assert property (!sup |=> !exec_done && !file_wr.en)
		else $error("spurious result");
endmodule // bcm_checker

bind bcm_execute bcm_checker bcm_checker_i (.clk_sys, .rst, .instr, .file_rd_data, .file_wr, .accum, .zero_flag,
	.exec_done);

// ===== bcm_regfile_model.sv
// Behavioural data register file facing the execute block
`timescale 1ns/1ps
module bcm_regfile_model
	import bcm_pkg::*;
(
	// Clock and execute side
	input wire logic clk_sys,
	input bcm_instr_type instr,
	input bcm_file_wr_type file_wr,
	output logic [DATA_W-1:0] file_rd_data
);
	logic [DATA_W-1:0] mem [32];
	// Forward the pending write, else back-to-back use of one register reads stale data
	assign file_rd_data = (file_wr.en && file_wr.addr == instr.word[4:0]) ? file_wr.data : mem[instr.word[4:0]];
	always @(posedge clk_sys)
		if (file_wr.en)
			mem[file_wr.addr] <= file_wr.data;
endmodule // bcm_regfile_model

// ===== testbench.sv
// Directed bench: instruction sequences and register accesses against expected results
`timescale 1ns/1ps
module testbench;
	import bcm_pkg::*;
	logic clk_sys = 0, rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, zero_flag, exec_done, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid;
	bcm_instr_type instr = '0;
	bcm_file_wr_type file_wr;
	logic [DATA_W-1:0] file_rd_data, accum;
	logic [REG_ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, rdv;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	int n_mismatch = 0, check_count = 0, cycles = 0;
	always #12.5 clk_sys = ~clk_sys;
	bcm_execute bcm_execute_i (.clk_sys, .rst, .instr, .file_rd_data, .file_wr, .accum, .zero_flag, .exec_done,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	bcm_regfile_model bcm_regfile_model_i (.clk_sys, .instr, .file_wr, .file_rd_data);
	task automatic final_report;
		if (n_mismatch == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Generous ceiling: the whole sequence needs about a hundred cycles
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			n_mismatch++;
			final_report;
		end
	end
	task automatic chk(input logic [31:0] got, exp);
		check_count++;
		if (got !== exp)
			n_mismatch++;
		if (got !== exp)
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
	endtask
	// Ready and valid are registered, so the level seen at the falling edge is the one sampled next
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		bit ra, rw, pa = 1, pw = 1;
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (pa || pw)
		begin
			@(negedge clk_sys);
			ra = s_axi_awready && pa;
			rw = s_axi_wready && pw;
			@(posedge clk_sys);
			if (ra)
				s_axi_awvalid <= 1'b0;
			if (rw)
				s_axi_wvalid <= 1'b0;
			pa = pa && !ra;
			pw = pw && !rw;
		end
		do
		begin
			@(negedge clk_sys);
			ra = s_axi_bvalid;
			rsp = s_axi_bresp;
			@(posedge clk_sys);
		end
		while (!ra);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a);
		bit r;
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(negedge clk_sys);
			r = s_axi_arready;
			@(posedge clk_sys);
		end
		while (!r);
		s_axi_arvalid <= 1'b0;
		do
		begin
			@(negedge clk_sys);
			r = s_axi_rvalid;
			rdv = s_axi_rdata;
			rsp = s_axi_rresp;
			@(posedge clk_sys);
		end
		while (!r);
		s_axi_rready <= 1'b0;
	endtask
	// Instruction held for one cycle; with last clear the next call follows back to back
	task automatic exec(input logic [11:0] w, input bit last);
		@(posedge clk_sys);
		instr <= '{1'b1, w};
		if (last)
		begin
			@(posedge clk_sys);
			instr.valid <= 1'b0;
			#1;
		end
	endtask
	initial
	begin
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		rd(OFS_CTRL);
		chk(rdv, 32'h1);
		chk(rsp, RESP_OKAY);
		rd(5'h10);
		chk(rsp, RESP_SLVERR);
		wr(5'h10, 32'h1);
		chk(rsp, RESP_SLVERR);
		wr(OFS_ACCUM, 32'h9a);
		exec(12'hd35, 1);
		chk({exec_done, zero_flag, file_wr.en, accum}, 11'h4bf);
		wr(OFS_ACCUM, 32'h0);
		exec(12'hd00, 1);
		chk({zero_flag, accum}, 9'h100);
		exec(12'hd01, 0);
		exec(12'hdfe, 1);
		chk({zero_flag, file_wr.en, accum}, 10'h0ff);
		bcm_regfile_model_i.mem[5] = 8'h13;
		wr(OFS_ACCUM, 32'h91);
		exec(12'h105, 1);
		chk({zero_flag, file_wr.en, accum}, 10'h093);
		wr(OFS_ACCUM, 32'h40);
		exec(12'h125, 1);
		chk({file_wr.en, file_wr.addr, file_wr.data, accum}, {1'b1, 5'd5, 8'h53, 8'h40});
		bcm_regfile_model_i.mem[31] = 8'hff;
		for (int b = 0; b < 8; b++)
		begin
			exec({4'h4, b[2:0], 5'd31}, 1);
			chk({zero_flag, file_wr.data}, {1'b0, 8'(8'hfe << b)});
		end
		exec(12'h23f, 1);
		chk({exec_done, zero_flag, file_wr.en, file_wr.data}, 11'h700);
		bcm_regfile_model_i.mem[8] = 8'h5a;
		exec(12'h208, 1);
		chk({zero_flag, file_wr.en, accum}, 10'h05a);
		exec(12'hfff, 1);
		chk({exec_done, accum}, 9'h05a);
		rd(OFS_STATUS);
		chk(rdv[STAT_UNSUP_POS], 1'b1);
		// Sixteen supported instructions were executed above
		rd(OFS_COUNT);
		chk(rdv, 32'd16);
		wr(OFS_CTRL, 32'h0);
		rd(OFS_CTRL);
		chk(rdv, 32'h0);
		// With execution off an instruction is dropped and nothing counts
		exec(12'hfff, 1);
		chk(exec_done, 1'b0);
		rd(OFS_STATUS);
		chk(rdv, 32'h6);
		wr(OFS_STATUS, 32'h6);
		chk(rsp, RESP_OKAY);
		rd(OFS_STATUS);
		chk(rdv, 32'h0);
		rd(OFS_COUNT);
		chk(rdv, 32'd16);
		// A write with the low strobe off must leave the accumulator alone
		s_axi_wstrb <= 4'he;
		wr(OFS_ACCUM, 32'h11);
		s_axi_wstrb <= 4'hf;
		rd(OFS_ACCUM);
		chk(rdv, 32'h5a);
		wr(OFS_CTRL, 32'h1);
		final_report;
	end
endmodule // testbench
